// ===== core/arl_result_limit_alert.sv
/*
 * Result formatting, limit comparison with hysteresis, sticky alert
 * status and the shared alert/busy output of a four-channel converter.
 * Assumes the serial interface assembles whole 16-bit words and gives
 * one write strobe per register write, and the converter engine gives
 * one pulse per finished conversion, all synchronous to core_clk.
 */
// Contract
// - Pin function follows two configuration bits
// - Writing 11 clears alert, flag, status
// - After clearing, pin bits read back 10
// - Result is sixteen-bit read-only straight binary
// - Flag, zero, tag, then sample MSB first
// - Ten-bit variant: two lowest bits zero
// - Tag is channel number in binary
// - Flag shows violation on any channel
// - Twelve limit registers, top four bits zero
// - Upper limits full scale, lower zero at reset
// - Alert when result above upper limit
// - Upper alert clears N below limit
// - Alert when result below lower limit
// - Lower alert clears N above limit
// - Hysteresis resets to 8 or 2
// - Violation shown on pin, flag or both
// - Configuration bit 0 sets pin polarity
// - Sticky per-limit status bits accumulate
`timescale 1ns/10ps

module arl_result_limit_alert #(
	parameter int RES_BITS = 12 // Converter resolution, 10 or 12
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire arl_pkg::arl_conv_s convIn,
	input wire logic convBusy,
	input wire arl_pkg::arl_reg_req_s regReq,
	output logic [15:0] regRdata,
	output logic alertBusy
);

	// Resolution dependent constants
	localparam logic [11:0] FULL_SCALE = (RES_BITS == 10) ?
		arl_pkg::FULL_SCALE_10 : arl_pkg::FULL_SCALE_12;
	localparam logic [11:0] HYST_INIT = (RES_BITS == 10) ?
		arl_pkg::HYST_RESET_10 : arl_pkg::HYST_RESET_12;
	localparam logic [11:0] SAMPLE_MASK = (RES_BITS == 10) ?
		arl_pkg::MASK_10 : arl_pkg::MASK_12;

	// Refuse resolutions the field layout cannot carry
	generate
		if (RES_BITS != 10 && RES_BITS != 12) begin : g_bad_res
			$error("RES_BITS must be 10 or 12");
		end
	endgenerate

	// Whole state of the block
	typedef struct packed {
		logic [7:0] cfg; // Configuration byte
		logic [3:0][11:0] upper; // Upper limits per channel
		logic [3:0][11:0] lower; // Lower limits per channel
		logic [3:0][11:0] hyst; // Hysteresis per channel
		logic [3:0] hiAct; // Upper alert active per channel
		logic [3:0] loAct; // Lower alert active per channel
		logic [7:0] status; // Sticky status, lo at 2c, hi at 2c+1
		logic [11:0] sample; // Last stored sample
		logic [1:0] chan; // Channel of the last sample
		logic [15:0] rdata; // Read word for the current pointer
		logic alertOut; // Pin level
	} arl_state_s;

	arl_state_s s_q; // Registered state
	arl_state_s s_d; // Next state

	logic [11:0] maskedSample; // Sample with unused low bits forced
	logic [3:0] hit; // Conversion belongs to this channel
	logic [3:0] tripHi; // Result above upper limit
	logic [3:0] tripLo; // Result below lower limit
	logic [3:0] relHi; // Result at least N below upper limit
	logic [3:0] relLo; // Result at least N above lower limit
	logic [15:0] resultWord; // Formatted result register
	logic anyAlert; // Any channel currently in violation
	logic [1:0] pinMode; // Pin function pair of the configuration
	logic pinPol; // Pin active level

	// Unused low bits of a 10-bit sample read as zero
	assign maskedSample = convIn.sample & SAMPLE_MASK;

	// Per-channel comparators, each against its own registers only
	generate
		for (genvar c = 0; c < arl_pkg::NUM_CHANNELS; c++) begin : g_cmp
			assign hit[c] = convIn.valid &&
				(convIn.chan == 2'(c));
			assign tripHi[c] = maskedSample > s_q.upper[c];
			assign tripLo[c] = maskedSample < s_q.lower[c];
			// Widened sums keep the hysteresis margin from wrapping
			assign relHi[c] = ({1'b0, maskedSample} + {1'b0, s_q.hyst[c]})
				<= {1'b0, s_q.upper[c]};
			assign relLo[c] = {1'b0, maskedSample} >=
				({1'b0, s_q.lower[c]} + {1'b0, s_q.hyst[c]});
		end
	endgenerate

	// Flag reflects any channel still in violation
	assign anyAlert = |{s_q.hiAct, s_q.loAct};

	// Result layout: flag, zero, tag, sample MSB first
	assign resultWord = {anyAlert, 1'b0, s_q.chan,
		s_q.sample};

	// Configuration fields used by the pin logic
	assign pinMode = s_q.cfg[arl_pkg::CFG_MODE_HI:arl_pkg::CFG_MODE_LO];
	assign pinPol = s_q.cfg[arl_pkg::CFG_POL_BIT];

	// Next state: register writes, then conversion updates
	always_comb begin
		s_d = s_q;
		// Register writes
		if (regReq.write) begin
			case (regReq.addr)
				arl_pkg::ADDR_CONFIG: begin
					s_d.cfg = regReq.wdata[7:0];
					// Clear code: drop alerts, read back as alert mode
					if (regReq.wdata[arl_pkg::CFG_MODE_HI:arl_pkg::CFG_MODE_LO]
						== arl_pkg::PIN_CLEAR) begin
						s_d.cfg[arl_pkg::CFG_MODE_HI:arl_pkg::CFG_MODE_LO] =
							arl_pkg::PIN_ALERT;
						s_d.status = '0;
						s_d.hiAct = '0;
						s_d.loAct = '0;
					end
				end
				arl_pkg::ADDR_STATUS: begin
					// All ones written to the status clears it
					if (regReq.wdata[7:0] == arl_pkg::STATUS_CLEAR) begin
						s_d.status = '0;
					end
				end
				arl_pkg::ADDR_RESULT: begin
					// Result is read only; writes are dropped
					s_d.cfg = s_q.cfg;
				end
				default: begin
					// Limit registers keep only the low twelve bits
					for (int c = 0; c < arl_pkg::NUM_CHANNELS; c++) begin
						if (regReq.addr == 4'(arl_pkg::ADDR_LIMIT_BASE +
							arl_pkg::LIMIT_STRIDE * 4'(c) +
							arl_pkg::LIMIT_LOWER)) begin
							s_d.lower[c] = regReq.wdata[11:0];
						end
						if (regReq.addr == 4'(arl_pkg::ADDR_LIMIT_BASE +
							arl_pkg::LIMIT_STRIDE * 4'(c) +
							arl_pkg::LIMIT_UPPER)) begin
							s_d.upper[c] = regReq.wdata[11:0];
						end
						if (regReq.addr == 4'(arl_pkg::ADDR_LIMIT_BASE +
							arl_pkg::LIMIT_STRIDE * 4'(c) +
							arl_pkg::LIMIT_HYST)) begin
							s_d.hyst[c] = regReq.wdata[11:0];
						end
					end
				end
			endcase
		end
		// Conversion comes after the clear so a new violation survives
		if (convIn.valid) begin
			s_d.sample = maskedSample;
			s_d.chan = convIn.chan;
		end
		for (int c = 0; c < arl_pkg::NUM_CHANNELS; c++) begin
			if (hit[c]) begin
				// Upper limit: set above, release N below
				if (tripHi[c]) begin
					s_d.hiAct[c] = 1'b1;
					s_d.status[2 * c + 1] = 1'b1;
				end else if (relHi[c]) begin
					s_d.hiAct[c] = 1'b0;
				end
				// Lower limit: set below, release N above
				if (tripLo[c]) begin
					s_d.loAct[c] = 1'b1;
					s_d.status[2 * c] = 1'b1;
				end else if (relLo[c]) begin
					s_d.loAct[c] = 1'b0;
				end
			end
		end
		// Read word for the pointer presented this cycle
		case (regReq.addr)
			arl_pkg::ADDR_RESULT: s_d.rdata = resultWord;
			arl_pkg::ADDR_STATUS: s_d.rdata = {8'h00, s_q.status};
			arl_pkg::ADDR_CONFIG: s_d.rdata = {8'h00, s_q.cfg};
			default: begin
				s_d.rdata = 16'h0000;
				for (int c = 0; c < arl_pkg::NUM_CHANNELS; c++) begin
					if (regReq.addr == 4'(arl_pkg::ADDR_LIMIT_BASE +
						arl_pkg::LIMIT_STRIDE * 4'(c) +
						arl_pkg::LIMIT_LOWER)) begin
						s_d.rdata = {4'h0, s_q.lower[c]};
					end
					if (regReq.addr == 4'(arl_pkg::ADDR_LIMIT_BASE +
						arl_pkg::LIMIT_STRIDE * 4'(c) +
						arl_pkg::LIMIT_UPPER)) begin
						s_d.rdata = {4'h0, s_q.upper[c]};
					end
					if (regReq.addr == 4'(arl_pkg::ADDR_LIMIT_BASE +
						arl_pkg::LIMIT_STRIDE * 4'(c) +
						arl_pkg::LIMIT_HYST)) begin
						s_d.rdata = {4'h0, s_q.hyst[c]};
					end
				end
			end
		endcase
		// Pin function and polarity
		case (pinMode)
			arl_pkg::PIN_BUSY: s_d.alertOut = convBusy ~^ pinPol;
			arl_pkg::PIN_ALERT: s_d.alertOut = anyAlert ~^ pinPol;
			default: s_d.alertOut = ~pinPol;
		endcase
	end

	// State register
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q.cfg <= arl_pkg::CFG_RESET;
			s_q.upper <= {4{FULL_SCALE}};
			s_q.lower <= {4{arl_pkg::ZERO_SCALE}};
			s_q.hyst <= {4{HYST_INIT}};
			s_q.hiAct <= 4'h0;
			s_q.loAct <= 4'h0;
			s_q.status <= 8'h00;
			s_q.sample <= 12'h000;
			s_q.chan <= 2'h0;
			s_q.rdata <= 16'h0000;
			s_q.alertOut <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flip-flops
	assign regRdata = s_q.rdata;
	assign alertBusy = s_q.alertOut;

	// Checks, all on the core clock and idle while reset is low
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// Pin function and polarity
	a_pin_off_idle: assert property (
		(pinMode == arl_pkg::PIN_OFF) |=> alertBusy == !$past(pinPol))
		else $error("pin not idle in off mode");
	a_pin_busy_follow: assert property (
		(pinMode == arl_pkg::PIN_BUSY)
		|=> alertBusy == ($past(convBusy) ~^ $past(pinPol)))
		else $error("busy output wrong");
	a_pin_alert_follow: assert property (
		(pinMode == arl_pkg::PIN_ALERT)
		|=> alertBusy == ($past(anyAlert) ~^ $past(pinPol)))
		else $error("alert output wrong");

	// Clearing through the pin function pair and the status register
	a_clear_all: assert property (
		(regReq.write && regReq.addr == arl_pkg::ADDR_CONFIG &&
		regReq.wdata[2:1] == arl_pkg::PIN_CLEAR && !convIn.valid)
		|=> s_q.status == 8'h00 && !anyAlert && !resultWord[15])
		else $error("clear did not clear");
	a_clear_readback: assert property (
		(regReq.write && regReq.addr == arl_pkg::ADDR_CONFIG &&
		regReq.wdata[2:1] == arl_pkg::PIN_CLEAR)
		|=> pinMode == arl_pkg::PIN_ALERT)
		else $error("clear code read back wrong");
	a_status_wr_clear: assert property (
		(regReq.write && regReq.addr == arl_pkg::ADDR_STATUS &&
		regReq.wdata[7:0] == arl_pkg::STATUS_CLEAR && !convIn.valid)
		|=> s_q.status == 8'h00)
		else $error("status write did not clear");
	a_status_sticky: assert property (
		(s_q.status != 8'h00 && !regReq.write)
		|=> (s_q.status & $past(s_q.status)) == $past(s_q.status))
		else $error("status bit lost");

	// Result word
	a_result_ro: assert property (
		(regReq.write && regReq.addr == arl_pkg::ADDR_RESULT &&
		!convIn.valid)
		|=> $stable(s_q.sample) && $stable(s_q.chan))
		else $error("result changed by write");
	a_read_result: assert property (
		(regReq.addr == arl_pkg::ADDR_RESULT)
		|=> regRdata == $past(resultWord))
		else $error("result read word wrong");
	a_result_layout: assert property (
		convIn.valid |=> resultWord[13:12] == $past(convIn.chan) &&
		!resultWord[14])
		else $error("result layout wrong");
	a_result_sample: assert property (
		convIn.valid |=> resultWord[11:0] ==
		($past(convIn.sample) & SAMPLE_MASK))
		else $error("result sample wrong");
	a_low_bits_zero: assert property (
		(RES_BITS == 10) |-> resultWord[1:0] == 2'h0)
		else $error("low bits not zero");
	a_flag_on_trip: assert property (
		(convIn.valid && (tripHi[convIn.chan] || tripLo[convIn.chan]))
		|=> resultWord[15])
		else $error("flag missing after violation");

	// Limits, hysteresis and per-channel isolation
	a_limit_top_zero: assert property (
		(regReq.addr >= arl_pkg::ADDR_LIMIT_BASE)
		|=> regRdata[15:12] == 4'h0)
		else $error("limit top bits not zero");
	a_upper_trip: assert property (
		(convIn.valid && tripHi[convIn.chan])
		|=> s_q.hiAct[$past(convIn.chan)] &&
		s_q.status[2 * $past(convIn.chan) + 1])
		else $error("upper violation missed");
	a_lower_trip: assert property (
		(convIn.valid && tripLo[convIn.chan])
		|=> s_q.loAct[$past(convIn.chan)] &&
		s_q.status[2 * $past(convIn.chan)])
		else $error("lower violation missed");
	a_upper_release: assert property (
		(convIn.valid && !tripHi[convIn.chan] && relHi[convIn.chan])
		|=> !s_q.hiAct[$past(convIn.chan)])
		else $error("upper alert not released");
	a_lower_release: assert property (
		(convIn.valid && !tripLo[convIn.chan] && relLo[convIn.chan])
		|=> !s_q.loAct[$past(convIn.chan)])
		else $error("lower alert not released");
	a_own_channel: assert property (
		(convIn.valid && !regReq.write)
		|=> ({s_q.hiAct, s_q.loAct} & ~{2{4'h1 << $past(convIn.chan)}})
		== ({$past(s_q.hiAct), $past(s_q.loAct)} &
		~{2{4'h1 << $past(convIn.chan)}}))
		else $error("other channel alert changed");

	// Main scenarios reached
	c_upper_hit: cover property (convIn.valid && tripHi[convIn.chan]);
	c_lower_hit: cover property (convIn.valid && tripLo[convIn.chan]);
	c_clear_write: cover property (regReq.write &&
		regReq.addr == arl_pkg::ADDR_CONFIG &&
		regReq.wdata[2:1] == arl_pkg::PIN_CLEAR && anyAlert);
	c_release: cover property (s_q.hiAct != 4'h0 ##[1:50]
		s_q.hiAct == 4'h0);
	c_busy_mode: cover property (pinMode == arl_pkg::PIN_BUSY && convBusy);

endmodule

// ===== core/arl_pkg.sv
/*
 * Shared constants and carrier types of the result formatter and limit
 * alarm block: register pointers, field positions, reset values.
 * Assumes a 4-bit register pointer and 16-bit register words supplied
 * by the serial interface logic that sits in front of this block.
 */
package arl_pkg;

	// Register pointer values
	localparam logic [3:0] ADDR_RESULT = 4'h0; // Conversion result, read only
	localparam logic [3:0] ADDR_STATUS = 4'h1; // Sticky alert status
	localparam logic [3:0] ADDR_CONFIG = 4'h2; // Configuration byte
	localparam logic [3:0] ADDR_LIMIT_BASE = 4'h4; // Lower limit of channel 0
	localparam logic [3:0] LIMIT_STRIDE = 4'h3; // Lower, upper, hysteresis
	localparam logic [3:0] LIMIT_LOWER = 4'h0; // Offset of lower limit
	localparam logic [3:0] LIMIT_UPPER = 4'h1; // Offset of upper limit
	localparam logic [3:0] LIMIT_HYST = 4'h2; // Offset of hysteresis value

	// Geometry
	localparam int NUM_CHANNELS = 4; // Analog inputs
	localparam int FIELD_BITS = 12; // Sample field width

	// Configuration byte fields
	localparam int CFG_POL_BIT = 0; // Active level of the shared pin
	localparam int CFG_MODE_LO = 1; // Low bit of the pin function pair
	localparam int CFG_MODE_HI = 2; // High bit of the pin function pair
	localparam logic [7:0] CFG_RESET = 8'h08; // Configuration after reset

	// Pin function codes
	localparam logic [1:0] PIN_OFF = 2'h0; // No signal on the pin
	localparam logic [1:0] PIN_BUSY = 2'h1; // Conversion busy output
	localparam logic [1:0] PIN_ALERT = 2'h2; // Limit alert output
	localparam logic [1:0] PIN_CLEAR = 2'h3; // Clear alerts, reads as alert

	// Result word fields
	localparam int RES_FLAG_BIT = 15; // Violation flag
	localparam int RES_ZERO_BIT = 14; // Constant zero
	localparam int RES_TAG_HI = 13; // Channel tag, upper bit
	localparam int RES_TAG_LO = 12; // Channel tag, lower bit

	// Reset values and masks
	localparam logic [11:0] FULL_SCALE_12 = 12'hfff; // Upper limit, 12-bit
	localparam logic [11:0] FULL_SCALE_10 = 12'hffc; // Upper limit, 10-bit
	localparam logic [11:0] ZERO_SCALE = 12'h000; // Lower limit reset
	localparam logic [11:0] HYST_RESET_12 = 12'h008; // Hysteresis, 12-bit
	localparam logic [11:0] HYST_RESET_10 = 12'h002; // Hysteresis, 10-bit
	localparam logic [11:0] MASK_12 = 12'hfff; // Sample mask, 12-bit
	localparam logic [11:0] MASK_10 = 12'hffc; // Sample mask, 10-bit
	localparam logic [7:0] STATUS_CLEAR = 8'hff; // Status write that clears

	// Completed conversion from the converter engine
	typedef struct packed {
		logic valid; // One-cycle pulse per finished conversion
		logic [1:0] chan; // Channel that was converted
		logic [11:0] sample; // Left-aligned sample
	} arl_conv_s;

	// Register access from the serial interface
	typedef struct packed {
		logic write; // One-cycle write strobe
		logic [3:0] addr; // Register pointer
		logic [15:0] wdata; // Assembled write word
	} arl_reg_req_s;

endpackage

// ===== test/arl_host_model.sv
/*
 * Host model: writes and reads whole 16-bit registers on the block's
 * register port. Assumes a free-running core_clk and a one-cycle strobe.
 */
`timescale 1ns/10ps

module arl_host_model (
	input wire logic core_clk,
	output arl_pkg::arl_reg_req_s regReq,
	input wire logic [15:0] regRdata
);
	// Idle request from time zero
	initial begin
		regReq = '0;
	end

	// One strobe per whole word; data scrambled once released
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		regReq <= '{write: 1'b1, addr: a, wdata: d};
		@(posedge core_clk);
		regReq.write <= 1'b0;
		regReq.wdata <= ~d;
	endtask

	// Pointer held until the registered answer; whole word taken
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge core_clk);
		regReq.addr <= a;
		repeat (2) @(posedge core_clk);
		#1 d = regRdata;
	endtask
endmodule

// ===== test/arl_result_limit_alert_bench.sv
/*
 * Self-checking bench of the result formatter and limit alarm.
 * Runs a 12-bit and a 10-bit build side by side on one stimulus and
 * assumes the host model for register access.
 */
`timescale 1ns/10ps

module arl_result_limit_alert_bench;
	logic core_clk; // 100 MHz clock
	logic reset_n; // Active-low reset
	arl_pkg::arl_conv_s convIn; // Finished conversion
	logic convBusy; // Converter busy level
	arl_pkg::arl_reg_req_s regReq; // Host request
	logic [15:0] regRdata; // Read word
	logic alertBusy; // Shared pin
	logic [15:0] regRdata10; // Read word, 10-bit build
	logic alertBusy10; // Shared pin, 10-bit build
	int error_cnt; // Mismatches
	int samples_checked; // Comparisons
	logic [15:0] rv; // Last read word

	arl_result_limit_alert #(.RES_BITS(12)) uut (.core_clk(core_clk),
		.reset_n(reset_n), .convIn(convIn), .convBusy(convBusy),
		.regReq(regReq), .regRdata(regRdata), .alertBusy(alertBusy));
	arl_result_limit_alert #(.RES_BITS(10)) uut10 (.core_clk(core_clk),
		.reset_n(reset_n), .convIn(convIn), .convBusy(convBusy),
		.regReq(regReq), .regRdata(regRdata10), .alertBusy(alertBusy10));
	arl_host_model host (.core_clk(core_clk), .regReq(regReq),
		.regRdata(regRdata));

	// Free-running clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Compare and count
	task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic test_done();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Pointer of a limit register of channel c
	function automatic logic [3:0] lim(int c, logic [3:0] off);
		return arl_pkg::ADDR_LIMIT_BASE + arl_pkg::LIMIT_STRIDE * 4'(c) + off;
	endfunction

	// Read a register and compare
	task automatic rdchk(logic [3:0] a, logic [15:0] exp, string n);
		host.rd(a, rv);
		check(n, rv, exp);
	endtask

	// Read a register and compare the word of the 10-bit build
	task automatic rd10(logic [3:0] a, logic [15:0] exp, string n);
		host.rd(a, rv);
		check(n, regRdata10, exp);
	endtask

	// One conversion pulse; sample scrambled afterwards
	task automatic conv(logic [1:0] c, logic [11:0] s);
		@(posedge core_clk);
		convIn <= '{valid: 1'b1, chan: c, sample: s};
		@(posedge core_clk);
		convIn.valid <= 1'b0;
		convIn.sample <= ~s;
	endtask

	// Result word: flag, zero, tag, sample
	task automatic res(logic f, logic [1:0] c, logic [11:0] s);
		rdchk(arl_pkg::ADDR_RESULT, {f, 1'b0, c, s}, "result");
	endtask

	// Pin level after it has settled
	task automatic pin(logic e);
		repeat (2) @(posedge core_clk);
		#1 check("pin", {15'h0, alertBusy}, {15'h0, e});
	endtask

	// Reset contents of every register except the result register
	task automatic t_reset();
		for (int c = 0; c < 4; c++) begin
			rdchk(lim(c, arl_pkg::LIMIT_LOWER), 16'h0000, "low");
			rdchk(lim(c, arl_pkg::LIMIT_UPPER), 16'h0fff, "up");
			rdchk(lim(c, arl_pkg::LIMIT_HYST), 16'h0008, "hyst");
			rd10(lim(c, arl_pkg::LIMIT_UPPER), 16'h0ffc, "up10");
			rd10(lim(c, arl_pkg::LIMIT_HYST), 16'h0002, "hyst10");
		end
		rdchk(arl_pkg::ADDR_CONFIG, 16'h0008, "config");
		rdchk(arl_pkg::ADDR_STATUS, 16'h0000, "status");
		pin(1'b1);
		check("pin10", {15'h0, alertBusy10}, 16'h0001);
	endtask

	// Masking, read-only result, tag of every channel
	task automatic t_format();
		host.wr(lim(0, arl_pkg::LIMIT_UPPER), 16'hf120);
		rdchk(lim(0, arl_pkg::LIMIT_UPPER), 16'h0120, "up0");
		host.wr(lim(0, arl_pkg::LIMIT_UPPER), 16'h0ffc);
		host.wr(arl_pkg::ADDR_RESULT, 16'hffff);
		rdchk(arl_pkg::ADDR_RESULT, 16'h0000, "ro");
		rdchk(4'h3, 16'h0000, "gap");
		for (int c = 0; c < 4; c++) begin
			conv(2'(c), 12'h5a0 + 12'(c));
			res(1'b0, 2'(c), 12'h5a0 + 12'(c));
			check("res10", regRdata10, {4'(c), 12'h5a0});
		end
	endtask

	// Upper limit: strict compare, hysteresis, flag of another channel
	task automatic t_upper();
		host.wr(arl_pkg::ADDR_CONFIG, 16'h0005);
		host.wr(lim(1, arl_pkg::LIMIT_UPPER), 16'h0800);
		conv(2'd1, 12'h800);
		res(1'b0, 2'd1, 12'h800);
		conv(2'd1, 12'h801);
		res(1'b1, 2'd1, 12'h801);
		pin(1'b1);
		rdchk(arl_pkg::ADDR_STATUS, 16'h0008, "status");
		conv(2'd2, 12'h100);
		res(1'b1, 2'd2, 12'h100);
		conv(2'd1, 12'h7f9);
		res(1'b1, 2'd1, 12'h7f9);
		conv(2'd1, 12'h7f8);
		res(1'b0, 2'd1, 12'h7f8);
		pin(1'b0);
		rdchk(arl_pkg::ADDR_STATUS, 16'h0008, "sticky");
	endtask

	// Lower limit, own channel only, hysteresis
	task automatic t_lower();
		host.wr(lim(2, arl_pkg::LIMIT_LOWER), 16'h0200);
		conv(2'd3, 12'h100);
		res(1'b0, 2'd3, 12'h100);
		conv(2'd2, 12'h1ff);
		res(1'b1, 2'd2, 12'h1ff);
		rdchk(arl_pkg::ADDR_STATUS, 16'h0018, "status");
		conv(2'd2, 12'h207);
		res(1'b1, 2'd2, 12'h207);
		conv(2'd2, 12'h208);
		res(1'b0, 2'd2, 12'h208);
	endtask

	// Clear through the pin function bits
	task automatic t_clear();
		conv(2'd2, 12'h1ff);
		pin(1'b1);
		host.wr(arl_pkg::ADDR_CONFIG, 16'h0007);
		rdchk(arl_pkg::ADDR_CONFIG, 16'h0005, "config");
		rdchk(arl_pkg::ADDR_STATUS, 16'h0000, "status");
		res(1'b0, 2'd2, 12'h1ff);
		pin(1'b0);
	endtask

	// Pin off, busy and alert roles at active-low polarity
	task automatic t_modes();
		conv(2'd2, 12'h1ff);
		host.wr(arl_pkg::ADDR_CONFIG, 16'h0000);
		pin(1'b1);
		res(1'b1, 2'd2, 12'h1ff);
		host.wr(arl_pkg::ADDR_CONFIG, 16'h0002);
		@(posedge core_clk);
		convBusy <= 1'b1;
		pin(1'b0);
		@(posedge core_clk);
		convBusy <= 1'b0;
		pin(1'b1);
		host.wr(arl_pkg::ADDR_CONFIG, 16'h0004);
		pin(1'b0);
	endtask

	// Main sequence
	initial begin
		error_cnt = 0;
		samples_checked = 0;
		reset_n = 1'b0;
		convIn = '0;
		convBusy = 1'b0;
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset();
		t_format();
		t_upper();
		t_lower();
		t_clear();
		t_modes();
		test_done();
	end
endmodule
